// file: common/area_bus_control_pkg.sv
// Types shared by the area bus control bank.
package area_bus_control_pkg;
	typedef logic [1:0] idle_code_t;
	typedef logic [2:0] idle_count_t;
	typedef logic [2:0] area_idx_t;
	typedef enum logic [3:0] {
		kind_normal    = 4'h0,
		kind_byte_sram = 4'h3,
		kind_sdram     = 4'h4,
		kind_pcmcia    = 4'h5
	} memory_kind_e;
	typedef enum {
		st_ready,
		st_idle
	} gap_state_e;
endpackage

// file: common/area_bus_control_regs.svh
// Register offsets, field positions, reset values and codes of the area bus control bank.
`ifndef AREA_BUS_CONTROL_REGS_SVH
`define AREA_BUS_CONTROL_REGS_SVH
`define ABC_OFF_AREA0       12'h000
`define ABC_OFF_AREA3       12'h004
`define ABC_OFF_AREA4       12'h008
`define ABC_OFF_AREA5       12'h00c
`define ABC_OFF_AREA6       12'h010
`define ABC_IW_HI           29
`define ABC_IW_LO           28
`define ABC_RWD_HI          26
`define ABC_RWD_LO          25
`define ABC_RWS_HI          23
`define ABC_RWS_LO          22
`define ABC_RRD_HI          20
`define ABC_RRD_LO          19
`define ABC_RRS_HI          17
`define ABC_RRS_LO          16
`define ABC_KIND_HI         15
`define ABC_KIND_LO         12
`define ABC_WIDTH_HI        10
`define ABC_WIDTH_LO        9
`define ABC_IDLE_RESET      2'h3
`define ABC_KIND_RESET      4'h0
`define ABC_WIDTH_RESET     2'h3
`define ABC_WIDTH_8         2'h1
`define ABC_WIDTH_16        2'h2
`define ABC_WIDTH_PIN_HI    2'h2
`define ABC_WIDTH_PIN_LO    2'h1
`define ABC_KIND_NORMAL     4'h0
`define ABC_KIND_BYTE_SRAM  4'h3
`define ABC_KIND_SDRAM      4'h4
`define ABC_KIND_PCMCIA     4'h5
`define ABC_WMASK           32'h36db_f600
`define ABC_IDLE_0          3'h0
`define ABC_IDLE_1          3'h1
`define ABC_IDLE_2          3'h2
`define ABC_IDLE_4          3'h4
`endif

// file: design/area_bus_control_config.sv
// APB register bank of per-area bus control words with an access gap sequencer.
//
// Function
// - Bits 20:19 set idle cycles between reads to different areas; reset four.
// - Bits 17:16 set idle cycles between reads to the same area; reset four.
// - Bits 15:12 pick memory kind: normal, byte SRAM, SDRAM, PCMCIA; reset normal.
// - Bits 10:9 set bus width: 01 eight bits, 10 sixteen bits.
// - Area zero width comes from the mode pin; written width is ignored.
// - Areas five and six as PCMCIA accept eight or sixteen bit width.
// - Reserved bits read zero; software writes zero to them.
// - Area zero captures the width mode pin at power-on reset release.
// - Bits 29:28 set idle cycles after a write; reset four.
// - Bits 26:25 set idle cycles for read then write to other area.
// - Bits 23:22 set idle cycles for read then write to same area.
//
// Design decisions made here: the APB interface to the registers and the placing of the registers.
`include "area_bus_control_regs.svh"
module area_bus_control_config (
	// Clock and reset.
	input  wire logic                                  pclk,
	input  wire logic                                  presetn,
	// APB slave.
	input  wire logic                                  psel,
	input  wire logic                                  penable,
	input  wire logic                                  pwrite,
	input  wire logic [11:0]                           paddr,
	input  wire logic [31:0]                           pwdata,
	output logic      [31:0]                           prdata,
	output wire logic                                  pready,
	output wire logic                                  pslverr,
	// Mode strap giving area zero its width.
	input  wire logic                                  width_mode_pin,
	// External access requests from the bus controller core.
	input  wire logic                                  acc_req,
	input  wire area_bus_control_pkg::area_idx_t       acc_area,
	input  wire logic                                  acc_write,
	output wire logic                                  acc_grant,
	// Configuration of the area of the granted access, and the gap busy flag.
	output area_bus_control_pkg::memory_kind_e         acc_kind,
	output logic      [1:0]                            acc_width,
	output logic                                       gap_busy
);
	import area_bus_control_pkg::*;

	localparam int NAREA = 5;

	// One word per implemented area: 0, 3, 4, 5 and 6 in that order.
	logic [31:0]  area_bus_control_reg [NAREA];
	logic [1:0]   area_zero_width;
	logic         strap_pending;
	gap_state_e   state;
	logic [2:0]   gap_left;
	logic [2:0]   prev_slot;
	logic         prev_write;
	logic         prev_valid;

	// APB decode: zero wait state, unmapped addresses answer with an error.
	wire          apb_access = psel & penable;
	wire          hit0 = (paddr == `ABC_OFF_AREA0);
	wire          hit3 = (paddr == `ABC_OFF_AREA3);
	wire          hit4 = (paddr == `ABC_OFF_AREA4);
	wire          hit5 = (paddr == `ABC_OFF_AREA5);
	wire          hit6 = (paddr == `ABC_OFF_AREA6);
	wire [NAREA-1:0] hit = {hit6, hit5, hit4, hit3, hit0};
	wire          mapped = |hit;
	assign pready  = 1'b1;
	assign pslverr = apb_access & ~mapped;

	// Reserved bits are dropped on write so they can never read back as one.
	wire [31:0]   wr_clean = pwdata & `ABC_WMASK;

	// Reset word shared by all areas: idle fields four, normal kind, width 11.
	localparam logic [31:0] RESET_WORD = {2'h0, `ABC_IDLE_RESET, 1'b0, `ABC_IDLE_RESET, 1'b0,
	                            `ABC_IDLE_RESET, 1'b0, `ABC_IDLE_RESET, 1'b0,
	                            `ABC_IDLE_RESET, `ABC_KIND_RESET, 1'b0,
	                            `ABC_WIDTH_RESET, 9'h000};

	// Register words; a write lands at the APB access edge only.
	genvar g;
	generate
		for (g = 0; g < NAREA; g++) begin : g_area
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					area_bus_control_reg[g] <= RESET_WORD;
				end else if (apb_access && pwrite && hit[g]) begin
					area_bus_control_reg[g] <= wr_clean;
				end
			end
		end
	endgenerate

	// The strap is sampled on the first clock after reset release, never under reset.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			strap_pending   <= 1'b1;
			area_zero_width <= `ABC_WIDTH_RESET;
		end else if (strap_pending) begin
			strap_pending   <= 1'b0;
			area_zero_width <= width_mode_pin ? `ABC_WIDTH_PIN_HI : `ABC_WIDTH_PIN_LO;
		end
	end

	// Area zero shows the strapped width in place of whatever was written.
	function automatic logic [31:0] view(input int idx);
		logic [31:0] w;
		w = area_bus_control_reg[idx];
		if (idx == 0) begin
			w[`ABC_WIDTH_HI:`ABC_WIDTH_LO] = area_zero_width;
		end
		return w;
	endfunction

	// Read mux: a one-hot select across the words, zero when nothing matches.
	always_comb begin
		prdata = 32'h0000_0000;
		for (int i = 0; i < NAREA; i++) begin
			if (hit[i]) begin
				prdata = view(i);
			end
		end
	end

	// Slot of the requesting area; unknown area numbers fall back to area zero.
	wire [2:0] req_slot = (acc_area == 3'h3) ? 3'h1 :
	                      (acc_area == 3'h4) ? 3'h2 :
	                      (acc_area == 3'h5) ? 3'h3 :
	                      (acc_area == 3'h6) ? 3'h4 : 3'h0;

	// Fields of the previous access's area, read live so a finished write counts.
	wire [31:0]   prev_word = view(32'(prev_slot));
	wire          same_area = (prev_slot == req_slot);
	// Word of the requesting area, named so its fields can be sliced.
	wire [31:0]   req_word = view(32'(req_slot));
	idle_count_t  cnt_ww;
	idle_count_t  cnt_rwd;
	idle_count_t  cnt_rws;
	idle_count_t  cnt_rrd;
	idle_count_t  cnt_rrs;

	idle_code_decode u_dec_ww (
		.code  (prev_word[`ABC_IW_HI:`ABC_IW_LO]),
		.count (cnt_ww)
	);
	idle_code_decode u_dec_rwd (
		.code  (prev_word[`ABC_RWD_HI:`ABC_RWD_LO]),
		.count (cnt_rwd)
	);
	idle_code_decode u_dec_rws (
		.code  (prev_word[`ABC_RWS_HI:`ABC_RWS_LO]),
		.count (cnt_rws)
	);
	idle_code_decode u_dec_rrd (
		.code  (prev_word[`ABC_RRD_HI:`ABC_RRD_LO]),
		.count (cnt_rrd)
	);
	idle_code_decode u_dec_rrs (
		.code  (prev_word[`ABC_RRS_HI:`ABC_RRS_LO]),
		.count (cnt_rrs)
	);

	// Classify the new access against the previous one by direction and area.
	wire [2:0] need_gap = !prev_valid ? 3'h0 :
	                      prev_write  ? cnt_ww :
	                      acc_write   ? (same_area ? cnt_rws : cnt_rwd) :
	                                    (same_area ? cnt_rrs : cnt_rrd);

	// A request goes straight through when no gap is owed.
	wire start_now = (state == st_ready) && acc_req && (need_gap == 3'h0);
	wire start_gap = (state == st_ready) && acc_req && (need_gap != 3'h0);
	wire gap_done  = (state == st_idle) && (gap_left == 3'h1);
	assign acc_grant = start_now || (gap_done && acc_req);

	// Gap sequencer: counts idle cycles then grants the held request.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state    <= st_ready;
			gap_left <= 3'h0;
		end else begin
			unique case (state)
				st_ready: begin
					if (start_gap) begin
						state    <= st_idle;
						gap_left <= need_gap;
					end
				end
				st_idle: begin
					gap_left <= gap_left - 3'h1;
					if (gap_done) begin
						state <= st_ready;
					end
				end
			endcase
		end
	end

	// History of the last granted access and its configuration snapshot.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prev_valid <= 1'b0;
			prev_write <= 1'b0;
			prev_slot  <= 3'h0;
			acc_kind   <= kind_normal;
			acc_width  <= `ABC_WIDTH_RESET;
		end else if (acc_grant) begin
			prev_valid <= 1'b1;
			prev_write <= acc_write;
			prev_slot  <= req_slot;
			acc_kind   <= memory_kind_e'(req_word[`ABC_KIND_HI:`ABC_KIND_LO]);
			acc_width  <= req_word[`ABC_WIDTH_HI:`ABC_WIDTH_LO];
		end
	end

	// Busy flag shown to the core while an idle gap runs.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gap_busy <= 1'b0;
		end else begin
			gap_busy <= start_gap || (state == st_idle && !gap_done);
		end
	end
endmodule // area_bus_control_config

// file: design/idle_code_decode.sv
// Decoder from a two-bit idle field code to a count of idle cycles.
`include "area_bus_control_regs.svh"
module idle_code_decode (
	// Field code in.
	input  wire area_bus_control_pkg::idle_code_t  code,
	// Idle cycles out.
	output wire area_bus_control_pkg::idle_count_t count
);
	import area_bus_control_pkg::*;

	// Codes 00, 01, 10 and 11 give zero, one, two and four idle cycles.
	assign count = (code == 2'h0) ? `ABC_IDLE_0 :
	               (code == 2'h1) ? `ABC_IDLE_1 :
	               (code == 2'h2) ? `ABC_IDLE_2 : `ABC_IDLE_4;
endmodule // idle_code_decode

// file: tb/access_requester.sv
// Model of the bus controller core that asks for external accesses.
module access_requester (
	// Clock and reset.
	input wire logic                            pclk,
	input wire logic                            presetn,
	// Command from the bench.
	input wire logic                            start,
	input wire area_bus_control_pkg::area_idx_t area,
	input wire logic                            wr,
	// Access handshake.
	input wire logic                            acc_grant,
	output logic                                acc_req,
	output area_bus_control_pkg::area_idx_t    acc_area,
	output logic                                acc_write,
	output logic [3:0]                          waited
);
	import area_bus_control_pkg::*;
	// Requests are held until granted; a released request shows inverted lines, not stale ones.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			acc_req   <= 1'b0;
			acc_area  <= 3'h0;
			acc_write <= 1'b0;
			waited    <= 4'h0;
		end else if (start && (!acc_req || acc_grant)) begin
			acc_req   <= 1'b1;
			acc_area  <= area;
			acc_write <= wr;
			waited    <= 4'h0;
		end else if (acc_req && acc_grant) begin
			acc_req   <= 1'b0;
			acc_area  <= ~acc_area;
			acc_write <= ~acc_write;
		end else if (acc_req)
			waited <= waited + 4'h1;
	end
endmodule // access_requester

// file: tb/area_bus_control_config_chk.sv
// Port-level assertions for the area bus control bank.
module area_bus_control_config_chk (
	// Clock and reset.
	input wire logic                           pclk,
	input wire logic                           presetn,
	// APB slave side.
	input wire logic                           psel,
	input wire logic                           penable,
	input wire logic                           pwrite,
	input wire logic [11:0]                    paddr,
	input wire logic [31:0]                    prdata,
	input wire logic                           pready,
	input wire logic                           pslverr,
	// Strap and access side.
	input wire logic                           width_mode_pin,
	input wire logic                           acc_req,
	input wire area_bus_control_pkg::area_idx_t acc_area,
	input wire logic                           acc_grant,
	input wire logic [1:0]                     acc_width,
	input wire logic                           gap_busy
);
	import area_bus_control_pkg::*;
	logic strap_seen;
	// Decoded read phase and the width the strap should give area zero.
	wire logic       rd      = psel && penable && !pwrite;
	wire logic [1:0] strap_w = width_mode_pin ? 2'h2 : 2'h1;
	// The strap is only captured at the first edge after reset, so reads before it are exempt.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			strap_seen <= 1'b0;
		else
			strap_seen <= 1'b1;
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	rsvd_zero_a: assert property (rd |-> (prdata & ~32'h36dbf600) == 32'h0)
		else $error("Reserved bits read nonzero.");
	zero_wait_a: assert property (psel && penable |-> pready)
		else $error("Access phase without ready.");
	unmapped_a: assert property (psel && penable && paddr > 12'h010 |-> pslverr && prdata == 32'h0)
		else $error("Unmapped access not refused.");
	grant_req_a: assert property (acc_grant |-> acc_req)
		else $error("Grant without request.");
	gap_bound_a: assert property (acc_req && !acc_grant |-> ##[1:4] acc_grant)
		else $error("Idle gap longer than four cycles.");
	area0_width_a: assert property (acc_grant && acc_area == 3'h0 |=> acc_width == strap_w)
		else $error("Area zero width not from strap.");
	strap_read_a: assert property (rd && paddr == 12'h000 && strap_seen |-> prdata[10:9] == strap_w)
		else $error("Area zero width field not strap.");
	cfg_hold_a: assert property (!acc_grant |=> $stable(acc_width))
		else $error("Width changed without grant.");
	gap_busy_a: assert property (acc_req && !acc_grant |=> gap_busy)
		else $error("Held request without busy gap.");
endmodule // area_bus_control_config_chk

bind area_bus_control_config area_bus_control_config_chk u_chk (.pclk, .presetn, .psel, .penable,
	.pwrite, .paddr, .prdata, .pready, .pslverr, .width_mode_pin, .acc_req, .acc_area, .acc_grant,
	.acc_width, .gap_busy);

// file: tb/area_bus_control_config_test.sv
// Self-checking bench for the area bus control bank.
module area_bus_control_config_test;
	timeunit 1ns;
	timeprecision 1ns;
	import area_bus_control_pkg::*;
	logic         pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic         width_mode_pin = 1, start = 0, wr = 0, err;
	logic [11:0]  paddr = 0;
	logic [31:0]  pwdata = 0, prdata, rdv;
	logic         pready, pslverr, acc_req, acc_write, acc_grant, gap_busy;
	logic [1:0]   acc_width;
	logic [3:0]   waited;
	area_idx_t    acc_area, area = 0;
	memory_kind_e acc_kind;
	int           miscompares = 0, num_checks = 0;
	area_idx_t    a2 [5] = '{3'h3, 3'h4, 3'h3, 3'h4, 3'h3};
	logic         w2 [5] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
	logic [3:0]   gaps [5] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h1};
	memory_kind_e kinds [4] = '{kind_normal, kind_byte_sram, kind_sdram, kind_pcmcia};
	area_bus_control_config u_area_bus_control_config (.pclk, .presetn, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr, .width_mode_pin, .acc_req, .acc_area,
		.acc_write, .acc_grant, .acc_kind, .acc_width, .gap_busy);
	access_requester u_access_requester (.pclk, .presetn, .start, .area, .wr, .acc_grant,
		.acc_req, .acc_area, .acc_write, .waited);
	// Free-running system clock.
	initial forever #5 pclk = ~pclk;
	// Whole run is under two hundred cycles, so this limit only trips on a hang.
	initial begin
		#200000;
		miscompares++;
		report_and_stop();
	end
	task automatic report_and_stop();
		if (miscompares == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", n, exp, got);
		end
	endtask
	task automatic rst(input logic pin);
		presetn <= 1'b0;
		width_mode_pin <= pin;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		repeat (2) @(posedge pclk);
	endtask
	// One APB transfer; an idle edge first keeps psel from being assigned twice in a step.
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (!pready);
		rdv = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk("prdata", rdv, exp);
	endtask
	task automatic go(input area_idx_t a, input logic w);
		area <= a;
		wr <= w;
		start <= 1'b1;
		do @(posedge pclk); while (acc_req && !acc_grant);
	endtask
	// Two back-to-back accesses; the wait before the second one is the idle gap.
	task automatic pair(input area_idx_t x, input logic xw, input area_idx_t y, input logic yw,
		input logic [3:0] n);
		go(x, xw);
		go(y, yw);
		start <= 1'b0;
		do @(posedge pclk); while (acc_req);
		chk("gap", {28'h0, waited}, {28'h0, n});
	endtask
	initial begin
		rst(1'b1);
		for (int i = 0; i < 5; i++)
			rdchk(12'(4 * i), i ? 32'h36db0600 : 32'h36db0400);
		rdchk(12'h014, 32'h0);
		chk("pslverr", {31'h0, err}, 32'h1);
		apb(1'b1, 12'h000, 32'h0000_0200);
		rdchk(12'h000, 32'h0000_0400);
		pair(3'h0, 1'b0, 3'h0, 1'b0, 4'h0);
		chk("acc_width", {30'h0, acc_width}, 32'h2);
		apb(1'b1, 12'h004, 32'hcbbd_4dff);
		rdchk(12'h004, 32'h0299_4400);
		for (int k = 0; k < 5; k++)
			pair(3'h3, k == 0, a2[k], w2[k], gaps[k]);
		chk("acc_kind", {28'h0, acc_kind}, {28'h0, kind_sdram});
		chk("acc_width", {30'h0, acc_width}, 32'h2);
		for (int i = 0; i < 4; i++) begin
			apb(1'b1, 12'h00c, {16'h0, kinds[i], 1'b0, i[0] ? 2'h1 : 2'h2, 9'h0});
			rdchk(12'h00c, {16'h0, kinds[i], 1'b0, i[0] ? 2'h1 : 2'h2, 9'h0});
		end
		pair(3'h5, 1'b1, 3'h5, 1'b0, 4'h0);
		chk("acc_kind", {28'h0, acc_kind}, {28'h0, kind_pcmcia});
		chk("acc_width", {30'h0, acc_width}, 32'h1);
		rst(1'b0);
		rdchk(12'h000, 32'h36db0200);
		pair(3'h0, 1'b0, 3'h0, 1'b0, 4'h4);
		chk("acc_width", {30'h0, acc_width}, 32'h1);
		report_and_stop();
	end
endmodule // area_bus_control_config_test
